// ---- hdl/csd_pkg.sv ----
// Constants and types for the channel switch settle delay block
package csd_pkg;

  // Register map
  localparam logic [5:0]  MODE_OFFSET    = 6'h01;
  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] MODE_WR_MASK   = 16'h877F;
  localparam int          DELAY_LSB      = 8;
  localparam int          DELAY_WIDTH    = 3;

  // Timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int UNIT_TIME_PS    = 8000000;
  localparam int UNIT_CYCLES     = (UNIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRE_WIDTH       = 11;
  localparam int UNIT_WIDTH      = 8;

  // Delay codes in units
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE0 = 8'h00;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE1 = 8'h01;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE2 = 8'h04;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE3 = 8'h0A;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE4 = 8'h19;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE5 = 8'h32;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE6 = 8'h7D;
  localparam logic [UNIT_WIDTH-1:0] UNITS_CODE7 = 8'hFA;

  typedef enum logic [0:0] {
    CSD_IDLE   = 1'b0,
    CSD_SETTLE = 1'b1
  } csd_state_type;

  typedef struct packed {
    csd_state_type          state;
    logic [PRE_WIDTH-1:0]   preCnt;
    logic [UNIT_WIDTH-1:0]  unitCnt;
    logic [15:0]            modeReg;
    logic                   convStart;
    logic                   filterReset;
    logic                   readyClear;
  } csd_regs_type;

  function automatic logic [UNIT_WIDTH-1:0] csd_units(input logic [DELAY_WIDTH-1:0] code);
    logic [UNIT_WIDTH-1:0] u;
    u = UNITS_CODE0;
    case (code)
      3'h1:    u = UNITS_CODE1;
      3'h2:    u = UNITS_CODE2;
      3'h3:    u = UNITS_CODE3;
      3'h4:    u = UNITS_CODE4;
      3'h5:    u = UNITS_CODE5;
      3'h6:    u = UNITS_CODE6;
      3'h7:    u = UNITS_CODE7;
      default: u = UNITS_CODE0;
    endcase
    return u;
  endfunction

endpackage

// ---- hdl/csd_settle_delay.sv ----
// Settling wait inserted between a channel switch and the next conversion start
`timescale 1ns/100ps
module csd_settle_delay #(
  // Timing
  parameter int UNIT_CYCLES = csd_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register write port
  input  wire logic [5:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  // Register read back
  output logic      [15:0] modeValue,
  // Sequencer side
  input  wire logic        chanSwitch,
  input  wire logic        multiChannel,
  input  wire logic        mainsReject,
  // Converter side
  output logic             convStart,
  output logic             filterReset,
  output logic             readyClear,
  output logic             settleBusy
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstSync1_reg;
  logic rstSync2_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit length
  localparam logic [csd_pkg::PRE_WIDTH-1:0] PRE_LAST =
    csd_pkg::PRE_WIDTH'(UNIT_CYCLES - 1);

  csd_pkg::csd_regs_type           r_reg;
  csd_pkg::csd_regs_type           r_next;
  logic                            modeWrite;
  logic [15:0]                     modeWrValue;
  logic [csd_pkg::DELAY_WIDTH-1:0] delayCode;
  logic [csd_pkg::UNIT_WIDTH-1:0]  units;
  logic                            delayBypass;
  logic                            switchTaken;
  logic                            unitTick;
  logic                            unitLast;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    modeWrite   = 1'b0;
    modeWrValue = r_reg.modeReg;
    if (!regWrEn) begin
      modeWrite = 1'b0;
    end else if (regAddr == csd_pkg::MODE_OFFSET) begin
      // Reserved bits never stored
      modeWrite   = 1'b1;
      modeWrValue = regWrData & csd_pkg::MODE_WR_MASK;
    end else begin
      // Other addresses have no effect here
      modeWrite = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit table, one entry per delay code
  logic [csd_pkg::UNIT_WIDTH-1:0] unitTable [1 << csd_pkg::DELAY_WIDTH];

  for (genvar g = 0; g < (1 << csd_pkg::DELAY_WIDTH); g++) begin : g_unitTable
    assign unitTable[g] = csd_pkg::csd_units(csd_pkg::DELAY_WIDTH'(g));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay selection
  always_comb begin
    delayCode   = r_reg.modeReg[csd_pkg::DELAY_LSB +: csd_pkg::DELAY_WIDTH];
    units       = unitTable[delayCode];
    // Single channel, mains rejection or code 0 skip the wait
    delayBypass = !multiChannel || mainsReject || (units == csd_pkg::UNITS_CODE0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch acceptance
  always_comb begin
    switchTaken = 1'b0;
    if (modeWrite) begin
      // Write wins over a switch in the same cycle
      switchTaken = 1'b0;
    end else if (r_reg.state == csd_pkg::CSD_IDLE) begin
      switchTaken = chanSwitch;
    end else begin
      // Switches during a wait are ignored
      switchTaken = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit divider
  always_comb begin
    unitTick = 1'b0;
    unitLast = 1'b0;
    if (r_reg.state == csd_pkg::CSD_SETTLE) begin
      // One enable pulse per elapsed delay unit
      unitTick = (r_reg.preCnt == PRE_LAST);
      unitLast = unitTick && (r_reg.unitCnt == csd_pkg::UNITS_CODE1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next             = r_reg;
    r_next.convStart   = 1'b0;
    r_next.filterReset = 1'b0;
    r_next.readyClear  = 1'b0;

    if (modeWrite) begin
      // Write aborts any wait and restarts conversion
      r_next.modeReg     = modeWrValue;
      r_next.filterReset = 1'b1;
      r_next.readyClear  = 1'b1;
      r_next.convStart   = 1'b1;
      r_next.state       = csd_pkg::CSD_IDLE;
      r_next.preCnt      = '0;
      r_next.unitCnt     = '0;
    end else begin
      case (r_reg.state)
        csd_pkg::CSD_IDLE: begin
          if (switchTaken && delayBypass) begin
            // Delay bypassed: unsupported with mains rejection
            r_next.convStart = 1'b1;
          end else if (switchTaken) begin
            r_next.state   = csd_pkg::CSD_SETTLE;
            r_next.preCnt  = '0;
            r_next.unitCnt = units;
          end
        end
        csd_pkg::CSD_SETTLE: begin
          if (unitLast) begin
            // Start only delayed; conversion period itself untouched
            r_next.state     = csd_pkg::CSD_IDLE;
            r_next.preCnt    = '0;
            r_next.unitCnt   = '0;
            r_next.convStart = 1'b1;
          end else if (unitTick) begin
            r_next.preCnt  = '0;
            r_next.unitCnt = r_reg.unitCnt - 8'h01;
          end else begin
            r_next.preCnt = r_reg.preCnt + 11'h001;
          end
        end
        default: begin
          r_next.state = csd_pkg::CSD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      r_reg.state       <= csd_pkg::CSD_IDLE;
      r_reg.preCnt      <= '0;
      r_reg.unitCnt     <= '0;
      r_reg.modeReg     <= csd_pkg::MODE_RESET;
      r_reg.convStart   <= 1'b0;
      r_reg.filterReset <= 1'b0;
      r_reg.readyClear  <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign modeValue   = r_reg.modeReg;
  assign convStart   = r_reg.convStart;
  assign filterReset = r_reg.filterReset;
  assign readyClear  = r_reg.readyClear;
  assign settleBusy  = (r_reg.state == csd_pkg::CSD_SETTLE);

endmodule

// ---- test/csd_settle_delay_chk.sv ----
// Assertions for the settle delay block
`timescale 1ns/100ps
module csd_settle_delay_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Register write port and read back
  input wire logic [5:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] modeValue,
  // Sequencer side
  input wire logic        chanSwitch,
  input wire logic        multiChannel,
  input wire logic        mainsReject,
  // Converter side
  input wire logic        convStart,
  input wire logic        filterReset,
  input wire logic        readyClear,
  input wire logic        settleBusy
);
  int          units[8] = '{0, 1, 4, 10, 25, 50, 125, 250};
  logic [19:0] busyCnt;
  logic        wr, sw, slow;
  assign wr = regWrEn && regAddr == 6'h01;
  assign sw = chanSwitch && !wr && !settleBusy;
  assign slow = multiChannel && !mainsReject && modeValue[10:8] != 3'h0;
  always_ff @(posedge ref_clk) busyCnt <= settleBusy ? busyCnt + 20'h00001 : 20'h00000;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_seen; wr; endsequence
  sequence pulses_out; filterReset && readyClear && convStart; endsequence
  a_write_pulses: assert property (wr_seen |=> pulses_out)
    else $error("write pulses missing");
  a_mode_store: assert property (wr |=> modeValue == ($past(regWrData) & 16'h877F))
    else $error("mode value wrong");
  a_reserved_zero: assert property ((modeValue & 16'h7880) == 16'h0000)
    else $error("reserved bits set");
  a_bypass_start: assert property (sw && !slow |=> convStart && !settleBusy)
    else $error("bypass start missing");
  a_settle_begin: assert property (sw && slow |=> settleBusy && !convStart)
    else $error("settle wait missing");
  a_busy_hold: assert property (settleBusy && !wr |=> settleBusy || convStart)
    else $error("wait ended without start");
  a_settle_len: assert property ($fell(settleBusy) && !$past(wr) |->
    busyCnt == 20'(units[modeValue[10:8]] * 1600)) else $error("wait length wrong");
  a_start_cause: assert property (convStart |->
    $past(wr) || $past(sw && !slow) || $fell(settleBusy)) else $error("stray start");
endmodule
bind csd_settle_delay csd_settle_delay_chk chk (
  .ref_clk      (ref_clk),
  .rst_n        (rst_n),
  .regAddr      (regAddr),
  .regWrEn      (regWrEn),
  .regWrData    (regWrData),
  .modeValue    (modeValue),
  .chanSwitch   (chanSwitch),
  .multiChannel (multiChannel),
  .mainsReject  (mainsReject),
  .convStart    (convStart),
  .filterReset  (filterReset),
  .readyClear   (readyClear),
  .settleBusy   (settleBusy)
);

// ---- test/csd_host.sv ----
// Host model issuing register writes
`timescale 1ns/100ps
module csd_host (
  // Clock
  input  wire logic   ref_clk,
  // Register write port
  output logic [5:0]  regAddr,
  output logic        regWrEn,
  output logic [15:0] regWrData
);
  initial {regAddr, regWrEn, regWrData} = 23'h000000;
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge ref_clk);
    {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
  endtask
endmodule

// ---- test/csd_settle_delay_test.sv ----
// Self-checking bench for the settle delay block
`timescale 1ns/100ps
module csd_settle_delay_test;
  logic        ref_clk = 0, rst_n = 0, chanSwitch = 0, multiChannel = 1, mainsReject = 0;
  logic        regWrEn, convStart, filterReset, readyClear, settleBusy;
  logic [5:0]  regAddr;
  logic [15:0] regWrData, modeValue;
  int          err_total = 0, comparisons = 0, n;
  int          units[8] = '{0, 1, 4, 10, 25, 50, 125, 250};
  always #2.5 ref_clk = ~ref_clk;
  csd_host host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData));
  csd_settle_delay dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .modeValue(modeValue), .chanSwitch(chanSwitch),
    .multiChannel(multiChannel), .mainsReject(mainsReject), .convStart(convStart),
    .filterReset(filterReset), .readyClear(readyClear), .settleBusy(settleBusy));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Pulse a channel switch for one cycle
  task automatic kick();
    @(negedge ref_clk) chanSwitch = 1;
    @(negedge ref_clk) chanSwitch = 0;
  endtask
  // Switch channel, count cycles to conversion start; cycle 1 follows the switch edge
  task automatic sw(input int lim);
    kick();
    n = 1;
    while (convStart !== 1'b1 && n <= lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (convStart !== 1'b1) begin
      err_total++;
      $display("mismatch %0t conversion start timed out", $time);
      summarize();
    end
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    cmp(modeValue, 16'h0000);
    cmp({filterReset, readyClear, convStart, settleBusy}, 16'h0000);
    host.wr(6'h01, 16'hFFFF);
    cmp({filterReset, readyClear, convStart}, 16'h0007);
    host.wr(6'h02, 16'h0000);
    cmp(modeValue, 16'h877F);
    for (int c = 0; c < 8; c++) begin
      host.wr(6'h01, 16'(c) << 8);
      if (c < 5) begin
        sw(units[c] * 1600 + 9);
        cmp(16'(n), 16'(units[c] * 1600 + 1));
      end else begin
        kick();
        repeat (100) @(negedge ref_clk);
        cmp({settleBusy, convStart}, 16'h0002);
        host.wr(6'h01, 16'h0700);
        cmp({settleBusy, convStart}, 16'h0001);
      end
    end
    multiChannel = 0;
    sw(9);
    cmp(16'(n), 16'h0001);
    {multiChannel, mainsReject} = 2'b11;
    sw(9);
    cmp(16'(n), 16'h0001);
    summarize();
  end
endmodule
